// ### rtl/dcsf_pkg.sv
/*
 * dcsf_pkg: shared constants for the dma status flag block.
 * assumes: imported by dcsf_tracker and dcsf_status_top; no clocks here.
 */
package dcsf_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int DCSF_NCH = 8; // dma channels
  localparam int DCSF_CHW = 4; // width of a channel code

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets (word aligned)
  localparam logic [3:0] DCSF_OFS_COLL = 4'h0; // dma_collision_status
  localparam logic [3:0] DCSF_OFS_ACT = 4'h4; // dma_channel_activity_status
  localparam logic [3:0] DCSF_OFS_IRQ_STAT = 4'h8; // sticky event status
  localparam logic [3:0] DCSF_OFS_IRQ_MASK = 4'hc; // event mask

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int DCSF_COLL_LSB = 0; // collision flags, bits 7..0
  localparam int DCSF_PP_LSB = 0; // ping-pong status, bits 7..0
  localparam int DCSF_LCH_LSB = 8; // last channel code, bits 11..8
  localparam int DCSF_EVT_XFER = 8; // event bit: any transfer completed
  localparam int DCSF_EVT_W = 9; // width of event status and mask

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [3:0] DCSF_LCH_NONE = 4'hf; // no transfer since reset
  localparam logic [7:0] DCSF_COLL_RST = 8'h00; // collision flags
  localparam logic [7:0] DCSF_PP_RST = 8'h00; // first start address in use
  localparam logic [8:0] DCSF_EVT_RST = 9'h000; // events and mask

  // bus slave phases
  typedef enum logic [1:0] {
    DCSF_BUS_IDLE,
    DCSF_BUS_WRITE,
    DCSF_BUS_RD_WAIT,
    DCSF_BUS_RD_DONE
  } dcsf_bus_e;

endpackage

// ### rtl/dcsf_track_if.sv
/*
 * dcsf_track_if: carries channel activity between the top and the tracker.
 * assumes: both ends are clocked by the same hclk.
 */
`timescale 1ns/100ps
interface dcsf_track_if;
  logic [7:0] xfer_done; // per-channel transfer completion pulse
  logic [7:0] pp_sel_b; // per-channel: second start address in use
  logic [3:0] last_ch; // registered last active channel code
  logic [7:0] pp_status; // registered ping-pong status
  logic xfer_any; // some channel completed this cycle

  modport tracker (input xfer_done, input pp_sel_b, output last_ch, output pp_status,
                   output xfer_any);
  modport owner (output xfer_done, output pp_sel_b, input last_ch, input pp_status,
                 input xfer_any);
endinterface

// ### rtl/dcsf_tracker.sv
/*
 * dcsf_tracker: remembers the last active channel and the ping-pong state.
 * assumes: xfer_done bits are one-cycle pulses synchronous to hclk.
 */
`timescale 1ns/100ps
module dcsf_tracker
  import dcsf_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  dcsf_track_if.tracker trk // channel activity
);

  //////////////////////////////////////////////////////////////////////////////
  // lowest-numbered completing channel wins a tie; binary channel code
  function automatic logic [3:0] dcsf_first_ch(input logic [7:0] req);
    logic [3:0] code;
    code = DCSF_LCH_NONE;
    for (int i = DCSF_NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        code = 4'(i);
      end
    end
    return code;
  endfunction

  assign trk.xfer_any = |trk.xfer_done;

  // last channel: updated on each completion, held otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trk.last_ch <= DCSF_LCH_NONE;
    end else if (trk.xfer_any) begin
      trk.last_ch <= dcsf_first_ch(trk.xfer_done);
    end
  end

  // ping-pong status mirrors which start address each channel uses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trk.pp_status <= DCSF_PP_RST;
    end else begin
      trk.pp_status <= trk.pp_sel_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_lch_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(trk.xfer_done[0]) |=> trk.last_ch == 4'h0)
    else $error("last channel not updated to channel 0");
  a_lch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !trk.xfer_any |=> $stable(trk.last_ch))
    else $error("last channel changed without a transfer");
  a_lch_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    trk.last_ch[3] |-> trk.last_ch == DCSF_LCH_NONE)
    else $error("reserved last channel code seen");
  // the first edge after reset release still shows the reset value, so it is skipped
  a_pp_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> trk.pp_status == $past(trk.pp_sel_b))
    else $error("ping-pong status does not follow select");

endmodule

// ### rtl/dcsf_status_top.sv
/*
 * dcsf_status_top: dma status flags behind an ahb-lite register slave.
 * assumes: one ahb-lite master, single word transfers, inputs synchronous to hclk.
 */
// Added by the designer: the register offsets and the AHB-Lite register port.
// Contract
// - per-channel collision flags in bits 7..0
// - flag reads one after collision, else zero
// - last channel code is plain binary 0..7, 0xf before any transfer
// - completion updates last channel; held otherwise
// - ping-pong bit one when second address used
`timescale 1ns/100ps
module dcsf_status_top
  import dcsf_pkg::*;
(
  input wire logic hclk, // system clock, 250 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data, registered
  output logic irq, // level interrupt, active high
  input wire logic [7:0] xfer_done, // per-channel completion pulse
  input wire logic [7:0] ram_wcol_det, // per-channel dma ram write collision pulse
  input wire logic [7:0] pp_sel_b // per-channel second start address in use
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  dcsf_bus_e bus_state; // bus slave phase
  logic [3:0] addr_q; // latched byte offset
  logic [7:0] coll_flag; // dma_ram_write_collision_flag per channel
  logic [8:0] evt_stat; // sticky event bits
  logic [8:0] evt_mask; // event enables
  logic [8:0] evt_in; // events arriving this cycle
  logic bus_take; // address phase accepted
  logic wr_now; // write data phase in progress
  logic [31:0] next_rdata; // read mux output
  dcsf_track_if trk(); // link to the tracker

  //////////////////////////////////////////////////////////////////////////////
  // register decode, used by read mux and write strobes
  function automatic logic dcsf_hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  assign trk.xfer_done = xfer_done;
  assign trk.pp_sel_b = pp_sel_b;

  dcsf_tracker u_tracker (
    .hclk(hclk),
    .hresetn(hresetn),
    .trk(trk)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: writes finish with no wait, reads take one wait state so the
  // read sees the result of a write that just went before it
  assign bus_take = hsel && htrans[1] && hready;
  assign wr_now = bus_state == DCSF_BUS_WRITE;
  assign hresp = 1'b0;

  // ready is low only in the first data cycle of a read
  always_comb begin
    hreadyout = bus_state != DCSF_BUS_RD_WAIT;
  end

  // phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= DCSF_BUS_IDLE;
      addr_q <= 4'h0;
    end else begin
      case (bus_state)
        DCSF_BUS_RD_WAIT: begin
          bus_state <= DCSF_BUS_RD_DONE; // data loaded, release ready
        end
        default: begin
          // idle, write or read done: a new address phase may start here
          if (bus_take) begin
            bus_state <= hwrite ? DCSF_BUS_WRITE : DCSF_BUS_RD_WAIT;
            addr_q <= haddr[3:0];
          end else begin
            bus_state <= DCSF_BUS_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (dcsf_hit(addr_q, DCSF_OFS_COLL)) begin
      next_rdata[DCSF_COLL_LSB +: 8] = coll_flag;
    end else if (dcsf_hit(addr_q, DCSF_OFS_ACT)) begin
      next_rdata[DCSF_LCH_LSB +: 4] = trk.last_ch;
      next_rdata[DCSF_PP_LSB +: 8] = trk.pp_status;
    end else if (dcsf_hit(addr_q, DCSF_OFS_IRQ_STAT)) begin
      next_rdata[8:0] = evt_stat;
    end else if (dcsf_hit(addr_q, DCSF_OFS_IRQ_MASK)) begin
      next_rdata[8:0] = evt_mask;
    end
  end

  // read data loads in the wait cycle and stands until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == DCSF_BUS_RD_WAIT) begin
      hrdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // collision flags: set by detection, cleared by writing zero to the bit;
  // a detection in the clearing cycle wins so no collision is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coll_flag <= DCSF_COLL_RST;
    end else if (wr_now && dcsf_hit(addr_q, DCSF_OFS_COLL)) begin
      coll_flag <= (coll_flag & hwdata[DCSF_COLL_LSB +: 8]) | ram_wcol_det;
    end else begin
      coll_flag <= coll_flag | ram_wcol_det;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt events: collisions in 7..0, any completion in bit 8
  assign evt_in = {trk.xfer_any, ram_wcol_det};

  // sticky status, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_stat <= DCSF_EVT_RST;
    end else if (wr_now && dcsf_hit(addr_q, DCSF_OFS_IRQ_STAT)) begin
      evt_stat <= (evt_stat & ~hwdata[8:0]) | evt_in;
    end else begin
      evt_stat <= evt_stat | evt_in;
    end
  end

  // mask register, plain read/write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_mask <= DCSF_EVT_RST;
    end else if (wr_now && dcsf_hit(addr_q, DCSF_OFS_IRQ_MASK)) begin
      evt_mask <= hwdata[8:0];
    end
  end

  // level output; registered so it never glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((evt_stat | evt_in) & evt_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_coll_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    ram_wcol_det[3] |=> coll_flag[3])
    else $error("collision flag 3 not set after detection");
  a_coll_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    coll_flag[0] && !(wr_now && dcsf_hit(addr_q, DCSF_OFS_COLL)) |=> coll_flag[0])
    else $error("collision flag 0 dropped without a clear");
  a_coll_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !coll_flag[1] && !ram_wcol_det[1] |=> !coll_flag[1])
    else $error("collision flag 1 set without detection");
  a_coll_read: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_state == DCSF_BUS_RD_WAIT && dcsf_hit(addr_q, DCSF_OFS_COLL)
      |=> hrdata[3:0] == $past(coll_flag[3:0]) && hrdata[31:8] == 24'h000000)
    else $error("collision register read mismatch");
  a_act_read: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_state == DCSF_BUS_RD_WAIT && dcsf_hit(addr_q, DCSF_OFS_ACT)
      |=> hrdata[11:8] == $past(trk.last_ch) && hrdata[31:12] == 20'h00000)
    else $error("activity register read mismatch");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
  // writes never stall the bus
  a_write_nowait: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_take && hwrite |=> hreadyout)
    else $error("write data phase stalled");

  // every channel's flag must follow its own detector, not only the sampled ones
  for (genvar g = 0; g < DCSF_NCH; g++) begin : g_coll_chk
    a_coll_each: assert property (@(posedge hclk) disable iff (!hresetn)
      ram_wcol_det[g] |=> coll_flag[g])
      else $error("collision flag not set after its detection");
  end

  // a zero write with no detection in the same cycle must drop the flag
  a_coll_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_now && dcsf_hit(addr_q, DCSF_OFS_COLL) && !hwdata[2] && !ram_wcol_det[2]
      |=> !coll_flag[2])
    else $error("collision flag 2 not cleared by a zero write");
  // writing a one over a set flag must keep it
  a_coll_keep_one: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_now && dcsf_hit(addr_q, DCSF_OFS_COLL) && hwdata[1] && coll_flag[1]
      |=> coll_flag[1])
    else $error("collision flag 1 lost on a one write");

  //////////////////////////////////////////////////////////////////////////////
  // event and interrupt checks; the status is what software polls when masked
  a_evt_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    trk.xfer_any |=> evt_stat[DCSF_EVT_XFER])
    else $error("completion event not latched");
  a_evt_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    evt_stat[DCSF_EVT_XFER] && !(wr_now && dcsf_hit(addr_q, DCSF_OFS_IRQ_STAT)
      && hwdata[DCSF_EVT_XFER]) |=> evt_stat[DCSF_EVT_XFER])
    else $error("completion event dropped without a clear");
  // a pending unmasked event must raise the line one cycle later
  a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    |(evt_stat & evt_mask) |=> irq)
    else $error("interrupt missing for a pending event");
  // with everything masked the line stays low whatever is pending
  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    evt_mask == 9'h000 |=> !irq)
    else $error("interrupt raised while fully masked");

endmodule

// ### dv/tb_dma_controller_status_flags.sv
/*
 * tb_dma_controller_status_flags: self-checking bench for the dma status flag block.
 * assumes: dcsf_pkg and the rtl files are compiled first; one ahb-lite master, hready looped back.
 */
`timescale 1ns/100ps
module tb_dma_controller_status_flags;
  import dcsf_pkg::*;
  logic hclk, hresetn, hsel, hwrite; // bus control
  logic [31:0] haddr, hwdata, hrdata, rd; // bus data
  logic [1:0] htrans; // transfer type
  logic [2:0] hsize; // always word
  logic hready, hreadyout, hresp, irq; // slave answers
  logic [7:0] xfer_done, ram_wcol_det, pp_sel_b; // channel side events
  int err_count, check_count; // verdict counters
  assign hready = hreadyout; // single slave drives bus ready

  dcsf_status_top u_dcsf_status_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .xfer_done(xfer_done), .ram_wcol_det(ram_wcol_det), .pp_sel_b(pp_sel_b));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks; every task is entered just after a rising edge
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single-word transfer; address held until hready, then data held until hready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata; // read data taken at the closing edge
  endtask

  // one-cycle event pulse on a channel bus
  task automatic pulse(input logic coll, input logic [7:0] v);
    if (coll) ram_wcol_det <= v;
    else xfer_done <= v;
    @(posedge hclk);
    ram_wcol_det <= 8'h00;
    xfer_done <= 8'h00;
    @(posedge hclk);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    pp_sel_b <= 8'h00; // status mirrors this, so park it at the reset value
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    ahb(1'b0, 32'h0, 32'h0);
    chk("collision status", 32'h0, rd);
    ahb(1'b0, 32'h4, 32'h0);
    chk("activity status", 32'h0000_0f00, rd);
    chk("irq", 32'h0, {31'h0, irq});
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset_values done");
  endtask

  task automatic t_collision();
    for (int ch = 0; ch < 8; ch++) begin
      pulse(1'b1, 8'h01 << ch);
      ahb(1'b1, 32'h0, 32'h0000_00ff); // writing ones must keep the flag
      ahb(1'b0, 32'h0, 32'h0);
      chk("flag set", 32'h1 << ch, rd);
      ahb(1'b1, 32'h0, 32'h0);
      ahb(1'b0, 32'h0, 32'h0);
      chk("flag cleared", 32'h0, rd);
    end
    $display("test collision done");
  endtask

  task automatic t_last_channel();
    for (int ch = 7; ch >= 0; ch--) begin
      pulse(1'b0, 8'h01 << ch);
      ahb(1'b0, 32'h4, 32'h0);
      chk("last channel", 32'(ch) << 8, rd);
    end
    repeat (5) @(posedge hclk);
    ahb(1'b1, 32'h4, 32'h0000_0f00); // read-only, ignored
    ahb(1'b0, 32'h4, 32'h0);
    chk("last channel held", 32'h0, rd);
    pulse(1'b0, 8'h28); // channels 5 and 3 together, lowest recorded
    ahb(1'b0, 32'h4, 32'h0);
    chk("simultaneous", 32'h0000_0300, rd);
    $display("test last_channel done");
  endtask

  task automatic t_pingpong();
    pp_sel_b <= 8'ha5;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0);
    chk("pingpong a5", 32'h0000_03a5, rd);
    pp_sel_b <= 8'h5a;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0);
    chk("pingpong 5a", 32'h0000_035a, rd);
    $display("test pingpong done");
  endtask

  task automatic t_irq();
    ahb(1'b1, 32'h8, 32'h0000_01ff); // clear old events
    pulse(1'b0, 8'h40); // masked out: no interrupt
    @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b0, 32'h8, 32'h0);
    chk("event status", 32'h0000_0100, rd);
    ahb(1'b1, 32'hc, 32'h0000_0100);
    ahb(1'b0, 32'hc, 32'h0);
    chk("mask", 32'h0000_0100, rd);
    repeat (2) @(posedge hclk);
    chk("irq pending", 32'h1, {31'h0, irq});
    ahb(1'b1, 32'h8, 32'h0000_0100);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    pulse(1'b0, 8'h02);
    @(posedge hclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    ahb(1'b0, 32'h4, 32'h0);
    chk("last after irq", 32'h0000_015a, rd);
    ahb(1'b1, 32'h8, 32'h0000_01ff); // drop pending events
    ahb(1'b1, 32'hc, 32'h0000_0008); // only channel 3 collisions interrupt
    pulse(1'b1, 8'h08);
    chk("irq on collision", 32'h1, {31'h0, irq});
    ahb(1'b0, 32'h8, 32'h0);
    chk("collision event", 32'h0000_0008, rd);
    $display("test irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // closing, main sequence and watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {xfer_done, ram_wcol_det, pp_sel_b} = '0;
    hresetn = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_collision();
    t_last_channel();
    t_pingpong();
    t_irq();
    do_reset(); // second reset in mid-run restores defaults
    t_reset_values();
    tally_and_finish();
  end

  // the run needs well under a thousand cycles; a hang ends it here
  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end
endmodule
